// >>> src/request_arbiter.sv
/*
  Priority interrupt controller: register file on the peripheral port,
  per-source level decode, priority encode, vector and fast vector
  generation, and the wake request used in wait and stop modes.
  Assumes request lines and the low-power flag come from logic on ref_clk.
*/
`timescale 1ns/1ps

module request_arbiter #(
  parameter int NUM_SRC = irq_arbiter_pkg::NUM_SOURCES,
  parameter int NUM_FIXED = irq_arbiter_pkg::FIXED_SOURCES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Peripheral register port
  input wire logic [irq_arbiter_pkg::REG_ADDR_W-1:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [irq_arbiter_pkg::DATA_W-1:0] reg_wdata,
  output logic [irq_arbiter_pkg::DATA_W-1:0] reg_rdata,
  // Interrupt request lines
  input wire logic [NUM_SRC-1:0] irq_req,
  // Core side
  output logic int_request,
  output logic [1:0] int_level,
  output logic [irq_arbiter_pkg::VEC_NUM_W-1:0] int_vector_num,
  output logic [irq_arbiter_pkg::VEC_ADDR_W-1:0] int_vector_addr,
  output logic int_fast,
  output logic addr_is_boot,
  // System integration unit
  input wire logic low_power_mode,
  output logic wake_request
);

  // Elaboration checks
  initial begin
    if (NUM_SRC != NUM_FIXED + irq_arbiter_pkg::NUM_PRIO_REGS
        * irq_arbiter_pkg::FIELDS_PER_REG) begin
      $error("source count does not match priority fields");
    end
    if (NUM_SRC > 64 || NUM_FIXED < 0) begin
      $error("unsupported source count");
    end
  end

  localparam int NPR = irq_arbiter_pkg::NUM_PRIO_REGS;
  localparam int DW = irq_arbiter_pkg::DATA_W;

  // Register storage
  logic [DW-1:0] prio_reg [NPR];
  logic [DW-1:0] vector_base_reg;
  logic [DW-1:0] fast_match_reg [2];
  logic [DW-1:0] fast_low_reg [2];
  logic [DW-1:0] fast_high_reg [2];
  logic [NUM_SRC-1:0] pending_reg;
  logic [NUM_SRC-1:0] sleep_enable_reg;
  logic boot_reg;

  // Core-side, wake and read-data registers
  logic int_request_reg;
  logic [1:0] int_level_reg;
  logic [irq_arbiter_pkg::VEC_NUM_W-1:0] vec_num_reg;
  logic [irq_arbiter_pkg::VEC_ADDR_W-1:0] vec_addr_reg;
  logic fast_reg;
  logic wake_reg;
  logic [DW-1:0] rdata_reg;
  logic [1:0] level_code_reg;

  // Write mask of one priority register
  function automatic logic [15:0] prio_wmask(input int idx);
    case (idx)
      0: prio_wmask = irq_arbiter_pkg::PRIO_WMASK_0;
      1: prio_wmask = irq_arbiter_pkg::PRIO_WMASK_1;
      2: prio_wmask = irq_arbiter_pkg::PRIO_WMASK_2;
      default: prio_wmask = irq_arbiter_pkg::PRIO_WMASK_N;
    endcase
  endfunction

  // Field to level decode; core-system fields sit one level higher
  function automatic logic [2:0] field_decode(input logic [1:0] fld, input logic core_src);
    logic [1:0] lvl;
    lvl = 2'h0;
    if (core_src) begin
      lvl = fld;
    end else begin
      lvl = fld - 2'h1;
    end
    field_decode = {fld != 2'h0, lvl};
  endfunction

  // Per-source enable and level
  logic [NUM_SRC-1:0] src_en;
  logic [1:0] src_lvl [NUM_SRC];

  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++) begin : g_src
      if (g < NUM_FIXED) begin : g_fixed
        // Fixed sources bypass the fields
        assign src_en[g] = 1'b1;
        assign src_lvl[g] = irq_arbiter_pkg::FIXED_LEVEL;
      end else begin : g_prog
        localparam int F = g - NUM_FIXED;
        localparam int R = F / irq_arbiter_pkg::FIELDS_PER_REG;
        localparam int B = 2 * (F % irq_arbiter_pkg::FIELDS_PER_REG);
        logic [2:0] dec;
        // Programmable level from the field
        assign dec = field_decode(prio_reg[R][B+1:B], R == 0);
        assign src_en[g] = dec[2];
        assign src_lvl[g] = dec[1:0];
      end
    end
  endgenerate

  // Enables in force: frozen while in low power
  logic [NUM_SRC-1:0] eff_en;
  assign eff_en = low_power_mode ? sleep_enable_reg : src_en;

  // Arbitration across and within levels
  logic win_found;
  logic [1:0] win_lvl;
  logic [5:0] win_idx;
  always_comb begin
    win_found = 1'b0;
    win_lvl = 2'h0;
    win_idx = 6'h00;
    // Descending scan; ties go to the lower number
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (irq_req[i] && eff_en[i] && (!win_found || src_lvl[i] >= win_lvl)) begin
        win_found = 1'b1;
        win_lvl = src_lvl[i];
        win_idx = 6'(i);
      end
    end
  end

  // Fast match, channel 0 first
  logic [irq_arbiter_pkg::VEC_NUM_W-1:0] win_vec;
  logic fast_hit0;
  logic fast_hit1;
  logic [irq_arbiter_pkg::VEC_ADDR_W-1:0] win_addr;
  assign win_vec = {1'b0, win_idx};
  assign fast_hit0 = win_lvl == irq_arbiter_pkg::FAST_LEVEL
    && win_vec == fast_match_reg[0][irq_arbiter_pkg::VEC_NUM_W-1:0];
  assign fast_hit1 = win_lvl == irq_arbiter_pkg::FAST_LEVEL
    && win_vec == fast_match_reg[1][irq_arbiter_pkg::VEC_NUM_W-1:0];

  // Vector address selection
  always_comb begin
    if (fast_hit0) begin
      win_addr = {fast_high_reg[0][4:0], fast_low_reg[0]};
    end else if (fast_hit1) begin
      win_addr = {fast_high_reg[1][4:0], fast_low_reg[1]};
    end else begin
      win_addr = {vector_base_reg[13:0], win_vec};
    end
  end

  // Level code presented to software
  logic [1:0] level_code;
  always_comb begin
    if (!win_found) begin
      level_code = irq_arbiter_pkg::CODE_NONE;
    end else begin
      case (win_lvl)
        2'h0: level_code = irq_arbiter_pkg::CODE_LEVEL0;
        2'h1: level_code = irq_arbiter_pkg::CODE_LEVEL1;
        default: level_code = irq_arbiter_pkg::CODE_LEVEL23;
      endcase
    end
  end

  // Priority register writes, reserved bits held at zero
  generate
    for (g = 0; g < NPR; g++) begin : g_prio
      always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
          prio_reg[g] <= irq_arbiter_pkg::PRIO_RESET;
        end else if (reg_wr_en && reg_addr == irq_arbiter_pkg::OFS_PRIO_0 + 5'(g)) begin
          prio_reg[g] <= reg_wdata & prio_wmask(g);
        end
      end
    end
  endgenerate

  // Vector base and fast channel registers
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      vector_base_reg <= irq_arbiter_pkg::VECTOR_BASE_RESET;
      fast_match_reg[0] <= irq_arbiter_pkg::FAST_RESET;
      fast_match_reg[1] <= irq_arbiter_pkg::FAST_RESET;
      fast_low_reg[0] <= irq_arbiter_pkg::FAST_RESET;
      fast_low_reg[1] <= irq_arbiter_pkg::FAST_RESET;
      fast_high_reg[0] <= irq_arbiter_pkg::FAST_RESET;
      fast_high_reg[1] <= irq_arbiter_pkg::FAST_RESET;
    end else if (reg_wr_en) begin
      case (reg_addr)
        irq_arbiter_pkg::OFS_VECTOR_BASE: vector_base_reg <= reg_wdata;
        irq_arbiter_pkg::OFS_FAST_MATCH_0: fast_match_reg[0] <= reg_wdata;
        irq_arbiter_pkg::OFS_FAST_LOW_0: fast_low_reg[0] <= reg_wdata;
        irq_arbiter_pkg::OFS_FAST_HIGH_0: fast_high_reg[0] <= reg_wdata;
        irq_arbiter_pkg::OFS_FAST_MATCH_1: fast_match_reg[1] <= reg_wdata;
        irq_arbiter_pkg::OFS_FAST_LOW_1: fast_low_reg[1] <= reg_wdata;
        irq_arbiter_pkg::OFS_FAST_HIGH_1: fast_high_reg[1] <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Pending snapshot taken every cycle; enables captured before low-power entry
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pending_reg <= '0;
      sleep_enable_reg <= '0;
    end else begin
      pending_reg <= irq_req & eff_en;
      if (!low_power_mode) begin
        sleep_enable_reg <= src_en;
      end
    end
  end

  // Wake request toward the system integration unit
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wake_reg <= 1'b0;
    end else begin
      wake_reg <= low_power_mode && (|(irq_req & sleep_enable_reg));
    end
  end

  // Core-side request, level, vector and fast flag
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      int_request_reg <= 1'b0;
      int_level_reg <= 2'h0;
      vec_num_reg <= '0;
      vec_addr_reg <= irq_arbiter_pkg::BOOT_ADDR;
      fast_reg <= 1'b0;
      level_code_reg <= irq_arbiter_pkg::CODE_NONE;
      boot_reg <= 1'b1;
    end else begin
      int_request_reg <= win_found;
      int_level_reg <= win_lvl;
      level_code_reg <= level_code;
      if (win_found) begin
        vec_num_reg <= win_vec;
        vec_addr_reg <= win_addr;
        fast_reg <= fast_hit0 || fast_hit1;
        boot_reg <= 1'b0;
      end else begin
        fast_reg <= 1'b0;
      end
    end
  end

  // Read data, registered; unmapped offsets read zero
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rdata_reg <= '0;
    end else if (reg_rd_en) begin
      rdata_reg <= '0;
      if (reg_addr <= irq_arbiter_pkg::OFS_PRIO_6) begin
        rdata_reg <= prio_reg[3'(reg_addr)];
      end else begin
        case (reg_addr)
          irq_arbiter_pkg::OFS_VECTOR_BASE: rdata_reg <= vector_base_reg;
          irq_arbiter_pkg::OFS_FAST_MATCH_0: rdata_reg <= fast_match_reg[0];
          irq_arbiter_pkg::OFS_FAST_LOW_0: rdata_reg <= fast_low_reg[0];
          irq_arbiter_pkg::OFS_FAST_HIGH_0: rdata_reg <= fast_high_reg[0];
          irq_arbiter_pkg::OFS_FAST_MATCH_1: rdata_reg <= fast_match_reg[1];
          irq_arbiter_pkg::OFS_FAST_LOW_1: rdata_reg <= fast_low_reg[1];
          irq_arbiter_pkg::OFS_FAST_HIGH_1: rdata_reg <= fast_high_reg[1];
          irq_arbiter_pkg::OFS_PENDING_0: rdata_reg <= pending_reg[15:0];
          irq_arbiter_pkg::OFS_PENDING_0 + 5'h1: rdata_reg <= pending_reg[31:16];
          irq_arbiter_pkg::OFS_PENDING_0 + 5'h2: rdata_reg <= pending_reg[47:32];
          irq_arbiter_pkg::OFS_PENDING_3: rdata_reg <= pending_reg[63:48];
          irq_arbiter_pkg::OFS_CONTROL: begin
            // Level code, vector number, fast flag and request state
            rdata_reg[irq_arbiter_pkg::CTRL_LEVEL_LSB +: 2] <= level_code_reg;
            rdata_reg[irq_arbiter_pkg::CTRL_VEC_LSB +: 7] <= vec_num_reg;
            rdata_reg[irq_arbiter_pkg::CTRL_FAST_BIT] <= fast_reg;
            rdata_reg[irq_arbiter_pkg::CTRL_REQ_BIT] <= int_request_reg;
          end
          default: rdata_reg <= '0;
        endcase
      end
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata = rdata_reg;
  assign int_request = int_request_reg;
  assign int_level = int_level_reg;
  assign int_vector_num = vec_num_reg;
  assign int_vector_addr = vec_addr_reg;
  assign int_fast = fast_reg;
  assign addr_is_boot = boot_reg;
  assign wake_request = wake_reg;

endmodule // request_arbiter

// >>> src/irq_arbiter_pkg.sv
/*
  Constants shared by the priority interrupt controller: register offsets,
  reset values, field layout, level codes and address widths.
  Assumes a 16-bit peripheral register port addressed in words.
*/
package irq_arbiter_pkg;

  // Source and register counts
  localparam int NUM_SOURCES = 64;
  localparam int FIXED_SOURCES = 8;
  localparam int NUM_PRIO_REGS = 7;
  localparam int FIELDS_PER_REG = 8;
  localparam int REG_ADDR_W = 5;
  localparam int DATA_W = 16;
  localparam int VEC_NUM_W = 7;
  localparam int VEC_ADDR_W = 21;

  // Register offsets, in words
  localparam logic [4:0] OFS_PRIO_0 = 5'h00;
  localparam logic [4:0] OFS_PRIO_6 = 5'h06;
  localparam logic [4:0] OFS_VECTOR_BASE = 5'h07;
  localparam logic [4:0] OFS_FAST_MATCH_0 = 5'h08;
  localparam logic [4:0] OFS_FAST_LOW_0 = 5'h09;
  localparam logic [4:0] OFS_FAST_HIGH_0 = 5'h0A;
  localparam logic [4:0] OFS_FAST_MATCH_1 = 5'h0B;
  localparam logic [4:0] OFS_FAST_LOW_1 = 5'h0C;
  localparam logic [4:0] OFS_FAST_HIGH_1 = 5'h0D;
  localparam logic [4:0] OFS_PENDING_0 = 5'h0E;
  localparam logic [4:0] OFS_PENDING_3 = 5'h11;
  localparam logic [4:0] OFS_CONTROL = 5'h16;

  // Reset values
  localparam logic [15:0] PRIO_RESET = 16'h0000;
  localparam logic [15:0] VECTOR_BASE_RESET = 16'h0000;
  localparam logic [15:0] FAST_RESET = 16'h0000;
  localparam logic [20:0] BOOT_ADDR = 21'h000000;

  // Writable bits of each priority register; reserved bits read zero
  localparam logic [15:0] PRIO_WMASK_0 = 16'hF3FF;
  localparam logic [15:0] PRIO_WMASK_1 = 16'hC03F;
  localparam logic [15:0] PRIO_WMASK_2 = 16'hC3FF;
  localparam logic [15:0] PRIO_WMASK_N = 16'hFFFF;

  // Level of a source whose priority is fixed
  localparam logic [1:0] FIXED_LEVEL = 2'h3;
  // Level that qualifies for fast handling
  localparam logic [1:0] FAST_LEVEL = 2'h2;

  // Field positions in the control register
  localparam int CTRL_LEVEL_LSB = 0;
  localparam int CTRL_VEC_LSB = 2;
  localparam int CTRL_FAST_BIT = 9;
  localparam int CTRL_REQ_BIT = 10;

  // Presented level codes
  typedef enum logic [1:0] {
    CODE_NONE = 2'h0,
    CODE_LEVEL0 = 2'h1,
    CODE_LEVEL1 = 2'h2,
    CODE_LEVEL23 = 2'h3
  } level_code_t;

endpackage

// >>> test/request_arbiter_chk.sv
/*
  Port checker for the interrupt arbiter.
  Assumes it is bound onto request_arbiter and shares its clock and reset.
*/
`timescale 1ns/1ps
module request_arbiter_chk #(
  parameter int NUM_SRC = irq_arbiter_pkg::NUM_SOURCES,
  parameter int NUM_FIXED = irq_arbiter_pkg::FIXED_SOURCES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [4:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  // Requests and core side
  input wire logic [NUM_SRC-1:0] irq_req,
  input wire logic int_request,
  input wire logic [1:0] int_level,
  input wire logic [6:0] int_vector_num,
  input wire logic [20:0] int_vector_addr,
  input wire logic int_fast,
  input wire logic addr_is_boot,
  // Wake path
  input wire logic low_power_mode,
  input wire logic wake_request
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  logic [NUM_SRC-1:0] req_d;

  // Requests one cycle back, to match the registered winner
  always_ff @(posedge ref_clk) begin
    req_d <= irq_req;
  end

  chk_fixed_wins: assert property (!low_power_mode && irq_req[0] |=> int_request &&
    int_level == 2'h3 && int_vector_num == 7'h00) else $error("fixed source lost");
  chk_idle_quiet: assert property (!(|irq_req) |=> !int_request && !int_fast)
    else $error("request without source");
  chk_winner_active: assert property (int_request |-> req_d[int_vector_num[5:0]])
    else $error("winner not requesting");
  chk_fast_level: assert property (int_fast |-> int_request && int_level == 2'h2)
    else $error("fast outside level two");
  chk_normal_addr: assert property (int_request && !int_fast |->
    int_vector_addr[6:0] == {1'b0, int_vector_num[5:0]}) else $error("vector offset wrong");
  chk_boot_addr: assert property (addr_is_boot |->
    int_vector_addr == irq_arbiter_pkg::BOOT_ADDR && !int_request) else $error("boot address");
  chk_wake_cause: assert property (wake_request |->
    $past(low_power_mode) && $past(irq_req) != '0) else $error("wake without cause");
  chk_wake_prompt: assert property (low_power_mode && irq_req[0] |=> wake_request)
    else $error("no wake");
  chk_vector_steady: assert property (int_request && $stable(irq_req) &&
    !$past(reg_wr_en) |=> $stable(int_vector_addr)) else $error("vector moved");
endmodule // request_arbiter_chk

bind request_arbiter request_arbiter_chk #(.NUM_SRC(NUM_SRC), .NUM_FIXED(NUM_FIXED)) chk_i (
  .ref_clk, .sys_rst, .reg_addr, .reg_wr_en, .reg_rd_en, .reg_wdata, .reg_rdata, .irq_req,
  .int_request, .int_level, .int_vector_num, .int_vector_addr, .int_fast, .addr_is_boot,
  .low_power_mode, .wake_request);

// >>> test/core_partner.sv
/*
  Model of the core and the clock restart unit beside the arbiter.
  Assumes it shares ref_clk and sys_rst with the arbiter.
*/
`timescale 1ns/1ps
module core_partner (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Bench controls
  input wire logic sleep_cmd,
  input wire logic [1:0] mask_bits,
  input wire logic vector_is_jump,
  // Arbiter outputs
  input wire logic int_request,
  input wire logic [1:0] int_level,
  input wire logic int_fast,
  input wire logic wake_request,
  // Back to arbiter and bench
  output logic low_power_mode,
  output logic core_accept,
  output logic fast_entered
);
  // Clocks stop on command and restart on a wake request
  always_ff @(posedge ref_clk) begin
    if (sys_rst || wake_request) begin
      low_power_mode <= 1'b0;
    end else if (sleep_cmd) begin
      low_power_mode <= 1'b1;
    end
  end

  // Core takes only levels at or above its mask
  assign core_accept = int_request && int_level >= mask_bits;

  // Fast handling only when the fetched vector word is no subroutine jump
  assign fast_entered = core_accept && int_fast && !vector_is_jump;
endmodule // core_partner

// >>> test/testbench.sv
/*
  Self-checking bench: a register and arbitration model compared with the arbiter.
  Assumes the bound checker and the core partner model.
*/
`timescale 1ns/1ps
module testbench;
  logic ref_clk = 1'h0;
  logic sys_rst = 1'h1;
  logic reg_wr_en = 1'h0;
  logic reg_rd_en = 1'h0;
  logic sleep_cmd = 1'h0;
  logic vector_is_jump = 1'h0;
  logic fast_entered;
  logic [1:0] mask_bits = '0;
  logic [4:0] reg_addr = '0;
  logic [15:0] reg_wdata = '0;
  logic [63:0] irq_req = '0;
  logic [15:0] reg_rdata;
  logic int_request, int_fast, addr_is_boot, low_power_mode, wake_request, core_accept;
  logic [1:0] int_level;
  logic [6:0] int_vector_num, e_num;
  logic [20:0] int_vector_addr, e_addr;
  logic [15:0] mregs [0:13];
  logic [63:0] q, e_pend;
  logic e_req, e_fast, e_boot, ok;
  int e_lvl;
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;
  int pk [10] = '{1, 2, 4, 5, 6, 7, 9, 10, 12, 13};
  integer seed = 32'hCC556BC3;

  request_arbiter dut (.ref_clk, .sys_rst, .reg_addr, .reg_wr_en, .reg_rd_en, .reg_wdata,
    .reg_rdata, .irq_req, .int_request, .int_level, .int_vector_num, .int_vector_addr,
    .int_fast, .addr_is_boot, .low_power_mode, .wake_request);
  core_partner partner (.ref_clk, .sys_rst, .sleep_cmd, .mask_bits, .vector_is_jump,
    .int_request, .int_level, .int_fast, .wake_request, .low_power_mode, .core_accept,
    .fast_entered);

  always #2 ref_clk = ~ref_clk;

  task complete_run;
    if (errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Hang guard
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      errors++;
      complete_run();
    end
  end

  task check(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task step;
    @(posedge ref_clk);
    #1;
  endtask

  // Expected winner and vector from the model registers
  function automatic void arb(input logic [63:0] r);
    int lv;
    int f;
    e_lvl = -1;
    e_fast = 1'h0;
    for (int s = 0; s < 64; s++) begin
      f = s < 8 ? 0 : int'(mregs[(s - 8) / 8][2 * ((s - 8) % 8) +: 2]);
      lv = s < 8 ? 3 : f == 0 ? -1 : s < 16 ? f : f - 1;
      e_pend[s] = r[s] && lv >= 0;
      if (r[s] && lv > e_lvl) begin
        e_lvl = lv;
        e_num = 7'(s);
      end
    end
    e_req = e_lvl >= 0;
    if (!e_req) return;
    e_boot = 1'h0;
    e_addr = {mregs[7][13:0], 1'b0, e_num[5:0]};
    e_fast = e_lvl == 2 && (e_num == mregs[8][6:0] || e_num == mregs[11][6:0]);
    if (e_fast) begin
      e_addr = e_num == mregs[8][6:0] ? {mregs[10][4:0], mregs[9]}
        : {mregs[13][4:0], mregs[12]};
    end
  endfunction

  function automatic logic [15:0] exp_rd(input logic [4:0] a);
    if (a <= 5'h0D) return mregs[a];
    if (a >= 5'h0E && a <= 5'h11) return e_pend[16 * (a - 5'h0E) +: 16];
    if (a == 5'h16) return {5'h00, e_req, e_fast, e_num, 2'(e_lvl >= 2 ? 3 : e_lvl + 1)};
    return 16'h0000;
  endfunction

  // One register access; reads compared with the model
  task acc(input logic w, input logic [4:0] a, input logic [15:0] d);
    logic [15:0] m;
    m = a == 0 ? 16'hF3FF : a == 1 ? 16'hC03F : a == 2 ? 16'hC3FF : 16'hFFFF;
    step();
    reg_addr = a;
    reg_wdata = d & m;
    reg_wr_en = w;
    reg_rd_en = !w;
    step();
    reg_wr_en = 1'h0;
    reg_rd_en = 1'h0;
    if (w && a <= 5'h0D) mregs[a] = d & m;
    if (!w) check(reg_rdata, exp_rd(a));
  endtask

  // Core side outputs one cycle after the requests
  task outs;
    step();
    arb(irq_req);
    check(int_request, e_req);
    if (e_req) check(int_level, e_lvl[1:0]);
    check(int_vector_num, e_num);
    check(int_vector_addr, e_addr);
    check(int_fast, e_fast);
    check(addr_is_boot, e_boot);
    check(wake_request, 1'h0);
    check(core_accept, e_req && e_lvl >= int'(mask_bits));
    check(fast_entered, e_fast && e_lvl >= int'(mask_bits) && !vector_is_jump);
  endtask

  task do_reset;
    sys_rst = 1'h1;
    repeat (3) step();
    sys_rst = 1'h0;
    foreach (mregs[i]) mregs[i] = 16'h0000;
    e_num = '0;
    e_addr = '0;
    e_boot = 1'h1;
    e_req = 1'h0;
    e_fast = 1'h0;
    e_lvl = -1;
    e_pend = '0;
    check(addr_is_boot, 1'h1);
    check(int_vector_addr, irq_arbiter_pkg::BOOT_ADDR);
    check(int_request, 1'h0);
  endtask

  initial begin
    do_reset();
    for (int a = 0; a < 32; a++) acc(1'h0, 5'(a), '0);
    for (int a = 0; a < 32; a++) acc(1'h1, 5'(a), 16'($random(seed)));
    for (int a = 0; a < 32; a++) acc(1'h0, 5'(a), '0);
    // Sources 33 and 32 at level two, one on each fast channel
    acc(1'h1, 5'h03, 16'h000F);
    acc(1'h1, 5'h08, 16'h0021);
    acc(1'h1, 5'h0B, 16'h0020);
    for (int i = 0; i < 300; i++) begin
      if (i % 8 == 7) acc(1'h1, 5'(pk[$unsigned($random(seed)) % 10]), 16'($random(seed)));
      q = {$random(seed), $random(seed)} & {$random(seed), $random(seed)};
      if (i % 4 != 0) q[7:0] = '0;
      if (i % 4 == 1) q = q & 64'h0000_00FF_0000_0000;
      irq_req = i % 5 == 0 ? '0 : q;
      mask_bits = 2'($random(seed));
      vector_is_jump = 1'($random(seed));
      outs();
      if (e_req) acc(1'h0, 5'h16, '0);
      acc(1'h0, 5'(14 + i % 4), '0);
    end
    // Sleep, enable a source late, then wake on an early one
    for (int i = 0; i < 2; i++) begin
      irq_req = '0;
      acc(1'h1, 5'h03, i ? 16'h000F : 16'h0003);
      sleep_cmd = 1'h1;
      step();
      sleep_cmd = 1'h0;
      acc(1'h1, 5'h03, 16'h003F);
      irq_req = i ? 64'h0000_0004_0000_0000 : 64'h0000_0002_0000_0000;
      repeat (3) begin
        step();
        check(wake_request, 1'h0);
      end
      irq_req = i ? 64'h0000_0000_0000_0001 : 64'h0000_0001_0000_0000;
      ok = 1'h0;
      repeat (4) begin
        step();
        ok = ok | wake_request;
      end
      check(ok, 1'h1);
    end
    irq_req = '0;
    do_reset();
    acc(1'h0, 5'h00, '0);
    acc(1'h0, 5'h07, '0);
    complete_run();
  end
endmodule // testbench
